/* rtl/sensor_clock_divider_sync.sv */
// Sensor end: pixel clock divider with frame-sync resynchronisation
`timescale 1ns/1ps
module sensor_clock_divider_sync #(
	parameter int FRAME_PIXELS = sensor_clock_pkg::FRAME_PIXELS,
	parameter int LEAD_PIXELS  = sensor_clock_pkg::SYNC_LEAD_PIXELS
) (
	input  wire logic        clk,
	input  wire logic        rst,
	sensor_clock_if.device   link,
	output logic             pixelEnable,
	output logic             timingReset,
	output logic             frameStart,
	output logic [1:0]       activeDivSel,
	output logic [7:0]       pixelCounterPreset,
	output logic             exposurePendingFlags,
	output logic [15:0]      pixelCount
);
	logic                                     anyReset;
	logic                                     syncMeta;
	logic                                     syncStable;
	logic                                     syncLast;
	logic [1:0]                               pendingDivSel;
	logic [sensor_clock_pkg::DIV_COUNT_WIDTH-1:0] divCount;
	logic [sensor_clock_pkg::DIV_COUNT_WIDTH-1:0] divLast;
	logic                                     endOfFrame;
	logic                                     syncRise;
	logic                                     divWrap;
	logic [15:0]                              lastPixel;
	logic [15:0]                              syncLoadPoint;

	// ********************************
	// Reset and frame-sync capture
	// ********************************
	// Pin reset taken on the clock, like rst
	assign anyReset = rst | ~link.systemResetN;

	// First flop feeds only the second one
	always_ff @(posedge clk) begin
		if (anyReset) begin
			syncMeta <= 1'b0;
		end else begin
			syncMeta <= link.frameSyncInput;
		end
	end

	always_ff @(posedge clk) begin
		if (anyReset) begin
			syncStable <= 1'b0;
		end else begin
			syncStable <= syncMeta;
		end
	end

	// Low after reset, matching the idle pin, so no false edge
	always_ff @(posedge clk) begin
		if (anyReset) begin
			syncLast <= 1'b0;
		end else begin
			syncLast <= syncStable;
		end
	end

	// ********************************
	// Frame-sync edge
	// ********************************
	assign syncRise = syncStable & ~syncLast;

	always_ff @(posedge clk) begin
		if (anyReset) begin
			timingReset <= 1'b0;
		end else begin
			timingReset <= syncRise;
		end
	end

	// ********************************
	// Divide select and pending flag
	// ********************************
	always_ff @(posedge clk) begin
		if (anyReset) begin
			pendingDivSel <= sensor_clock_pkg::DIV_SEL_RESET;
		end else if (link.writeStrobe) begin
			pendingDivSel <= link.writeDivSel;
		end
	end

	// Latest write wins until the frame swaps it in
	// Deferred so a frame never mixes two pixel rates
	always_ff @(posedge clk) begin
		if (anyReset) begin
			activeDivSel <= sensor_clock_pkg::DIV_SEL_RESET;
		end else if (frameStart) begin
			activeDivSel <= pendingDivSel;
		end
	end

	// Write in the frame-start cycle wins over the clear
	always_ff @(posedge clk) begin
		if (anyReset) begin
			exposurePendingFlags <= 1'b0;
		end else if (link.writeStrobe) begin
			exposurePendingFlags <= 1'b1;
		end else if (frameStart) begin
			exposurePendingFlags <= 1'b0;
		end
	end

	// ********************************
	// Preset register
	// ********************************
	// Only held here; the load point is fixed by LEAD_PIXELS
	always_ff @(posedge clk) begin
		if (anyReset) begin
			pixelCounterPreset <= sensor_clock_pkg::PRESET_RESET;
		end else if (link.writePreset) begin
			pixelCounterPreset <= link.writePresetValue;
		end
	end

	// ********************************
	// Divider
	// ********************************
	// Terminal count is the divisor minus one
	always_comb begin
		unique case (sensor_clock_pkg::div_sel_type'(activeDivSel))
			sensor_clock_pkg::DIV_BY_2:  divLast = 4'h1;
			sensor_clock_pkg::DIV_BY_4:  divLast = 4'h3;
			sensor_clock_pkg::DIV_BY_8:  divLast = 4'h7;
			sensor_clock_pkg::DIV_BY_16: divLast = 4'hF;
		endcase
	end

	// ********************************
	// Divide counter
	// ********************************
	// Wraps on a smaller divisor too, when the select drops mid count
	assign divWrap = (divCount >= divLast);

	// Counts only while the oscillator runs; gated clock input modelled as enable
	always_ff @(posedge clk) begin
		if (anyReset || timingReset) begin
			divCount <= '0;
		end else if (link.oscillatorInputEn) begin
			if (divWrap) begin
				divCount <= '0;
			end else begin
				divCount <= divCount + 4'h1;
			end
		end
	end

	// ********************************
	// Pixel clock enable
	// ********************************
	// Held low in the sync pulse so no pixel straddles the reload
	assign pixelEnable = link.oscillatorInputEn && (divCount == divLast) && !timingReset;

	// ********************************
	// Frame timing position
	// ********************************
	assign lastPixel     = 16'(FRAME_PIXELS - 1);
	assign syncLoadPoint = 16'(FRAME_PIXELS - LEAD_PIXELS);
	assign endOfFrame    = (pixelCount == lastPixel);

	// Sync point sits LEAD_PIXELS before the frame wraps
	always_ff @(posedge clk) begin
		if (anyReset) begin
			pixelCount <= '0;
		end else if (timingReset) begin
			pixelCount <= syncLoadPoint;
		end else if (pixelEnable) begin
			if (endOfFrame) begin
				pixelCount <= '0;
			end else begin
				pixelCount <= pixelCount + 16'h0001;
			end
		end
	end

	// ********************************
	// Frame start
	// ********************************
	// Registered so the divide select swaps on a clean edge
	always_ff @(posedge clk) begin
		if (anyReset) begin
			frameStart <= 1'b0;
		end else begin
			frameStart <= pixelEnable & endOfFrame & ~timingReset;
		end
	end
endmodule

/* rtl/sensor_clock_pkg.sv */
// Shared constants and types for the sensor clock divider and its host
package sensor_clock_pkg;
	localparam int DIV_SEL_WIDTH = 2;
	localparam logic [1:0] DIV_SEL_RESET = 2'h0;
	localparam int DIV_COUNT_WIDTH = 4;
	localparam logic [7:0] PRESET_REQUIRED = 8'h1E;
	localparam logic [7:0] PRESET_RESET = 8'h00;
	localparam int SYNC_LEAD_PIXELS = 5;
	localparam int QUIET_CYCLES = 16;
	localparam logic [4:0] QUIET_COUNT = 5'h10;
	localparam int FRAME_PIXELS = 1024;
	typedef enum logic [1:0] {
		DIV_BY_2,
		DIV_BY_4,
		DIV_BY_8,
		DIV_BY_16
	} div_sel_type;
	typedef enum {
		HOST_IDLE,
		HOST_PRE,
		HOST_SEND,
		HOST_POST
	} host_state_type;
endpackage

/* rtl/sensor_clock_if.sv */
// Link between the host controller and the sensor clock block
`timescale 1ns/1ps
interface sensor_clock_if;
	logic       oscillatorInputEn;
	logic       frameSyncInput;
	logic       systemResetN;
	logic       writeStrobe;
	logic [1:0] writeDivSel;
	logic       writePreset;
	logic [7:0] writePresetValue;
	logic       busActive;
	modport device (
		input oscillatorInputEn,
		input frameSyncInput,
		input systemResetN,
		input writeStrobe,
		input writeDivSel,
		input writePreset,
		input writePresetValue,
		input busActive
	);
	modport host (
		output oscillatorInputEn,
		output frameSyncInput,
		output systemResetN,
		output writeStrobe,
		output writeDivSel,
		output writePreset,
		output writePresetValue,
		output busActive
	);
endinterface

/* rtl/sensor_clock_host.sv */
// Host end: drives clock enable, frame sync and register writes
`timescale 1ns/1ps
module sensor_clock_host #(
	parameter int HALF_PERIOD = 2048
) (
	input  wire logic       clk,
	input  wire logic       rst,
	sensor_clock_if.host    link,
	input  wire logic       syncRun,
	input  wire logic       clockStop,
	input  wire logic       writeReq,
	input  wire logic [1:0] writeDivSel,
	input  wire logic       fastClock,
	output logic            writeBusy,
	output logic            writeDone
);
	sensor_clock_pkg::host_state_type state;
	logic [4:0]  quietCount;
	logic [1:0]  heldSel;
	logic [31:0] syncCount;
	logic        presetDone;

	always_ff @(posedge clk) begin
		if (rst) begin
			state      <= sensor_clock_pkg::HOST_IDLE;
			quietCount <= '0;
			heldSel    <= sensor_clock_pkg::DIV_SEL_RESET;
			writeDone  <= 1'b0;
		end else begin
			writeDone <= 1'b0;
			unique case (state)
				sensor_clock_pkg::HOST_IDLE: if (writeReq) begin
					// Divide by 2 is refused on a fast clock
					heldSel    <= (fastClock && writeDivSel == 2'h0) ? 2'h1 : writeDivSel;
					quietCount <= '0;
					state      <= sensor_clock_pkg::HOST_PRE;
				end
				sensor_clock_pkg::HOST_PRE: begin
					quietCount <= quietCount + 5'h01;
					if (quietCount == sensor_clock_pkg::QUIET_COUNT - 5'h01) begin
						state <= sensor_clock_pkg::HOST_SEND;
					end
				end
				sensor_clock_pkg::HOST_SEND: begin
					quietCount <= '0;
					state      <= sensor_clock_pkg::HOST_POST;
				end
				sensor_clock_pkg::HOST_POST: begin
					quietCount <= quietCount + 5'h01;
					if (quietCount == sensor_clock_pkg::QUIET_COUNT - 5'h01) begin
						writeDone <= 1'b1;
						state     <= sensor_clock_pkg::HOST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			presetDone <= 1'b0;
		end else begin
			presetDone <= 1'b1;
		end
	end

	assign link.writePreset      = rst ? 1'b0 : ~presetDone;
	assign link.writePresetValue = sensor_clock_pkg::PRESET_REQUIRED;
	assign link.writeStrobe      = (state == sensor_clock_pkg::HOST_SEND);
	assign link.writeDivSel      = heldSel;
	assign link.busActive        = (state != sensor_clock_pkg::HOST_IDLE);
	assign link.oscillatorInputEn = link.busActive | ~clockStop;
	assign link.systemResetN     = ~rst;
	assign writeBusy             = link.busActive;

	// Sync level toggles each half period, one rise per two frames at divide by 2
	always_ff @(posedge clk) begin
		if (rst || !syncRun) begin
			syncCount          <= '0;
			link.frameSyncInput <= 1'b0;
		end else if (syncCount == 32'(HALF_PERIOD - 1)) begin
			syncCount          <= '0;
			link.frameSyncInput <= ~link.frameSyncInput;
		end else begin
			syncCount <= syncCount + 32'h0000_0001;
		end
	end
endmodule

/* verification/sensor_clock_divider_sync_sva.sv */
// Checker watching the link between host and sensor ends
`timescale 1ns/1ps
module sensor_clock_divider_sync_sva (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       oscillatorInputEn,
	input wire logic       frameSyncInput,
	input wire logic       systemResetN,
	input wire logic       writeStrobe,
	input wire logic       writePreset,
	input wire logic [7:0] writePresetValue,
	input wire logic       busActive,
	input wire logic       pixelEnable,
	input wire logic       timingReset,
	input wire logic       frameStart,
	input wire logic [1:0] activeDivSel,
	input wire logic       exposurePendingFlags
);
	// ****
	// Properties
	// ****
	// Either reset clears the device, so both silence the checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst || !systemResetN);
	a_bus_pre_quiet: assert property (writeStrobe |-> oscillatorInputEn && $past(busActive, 16))
		else $error("clock idle before write");
	a_bus_post_quiet: assert property (writeStrobe |-> ##16 oscillatorInputEn)
		else $error("clock idle after write");
	a_preset_value: assert property (writePreset |-> writePresetValue == sensor_clock_pkg::PRESET_REQUIRED)
		else $error("wrong preset value");
	a_sync_delay: assert property ($rose(frameSyncInput) |-> ##3 timingReset)
		else $error("timing reset late");
	a_sync_single: assert property (timingReset |=> !timingReset)
		else $error("timing reset too long");
	a_pending_set: assert property (writeStrobe |=> exposurePendingFlags)
		else $error("pending not set");
	a_pending_clear: assert property (frameStart && !writeStrobe && !$past(writeStrobe) |-> ##[0:1] !exposurePendingFlags)
		else $error("pending not cleared");
	a_div_hold: assert property (!frameStart && !$past(frameStart) |-> $stable(activeDivSel))
		else $error("divider changed mid frame");
	a_pixel_gap: assert property (pixelEnable && !timingReset |=> !pixelEnable)
		else $error("pixel enables adjacent");
endmodule

/* verification/sensor_clock_divider_sync_bench.sv */
// Bench joining host and sensor ends
`timescale 1ns/1ps
module sensor_clock_divider_sync_bench;
	localparam int FRAME = 16;
	localparam int HALF  = 32;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        syncRun = 1'b0;
	logic        clockStop = 1'b0;
	logic        writeReq = 1'b0;
	logic [1:0]  writeDivSel = 2'h0;
	logic        fastClock = 1'b0;
	logic        writeDone;
	logic        writeBusy;
	logic        pixelEnable;
	logic        timingReset;
	logic        frameStart;
	logic        exposurePendingFlags;
	logic        strobe;
	logic [1:0]  activeDivSel;
	logic [7:0]  pixelCounterPreset;
	logic [15:0] pixelCount;
	logic [15:0] gap;
	logic [31:0] seed = 32'h0000_3cb7;
	int          errors = 0;
	int          n_compared = 0;
	int          cycles = 0;
	sensor_clock_if link ();
	assign strobe = link.writeStrobe;
	sensor_clock_divider_sync #(.FRAME_PIXELS(FRAME)) sensor_clock_divider_sync_inst (.clk, .rst, .link,
		.pixelEnable, .timingReset, .frameStart, .activeDivSel, .pixelCounterPreset, .exposurePendingFlags, .pixelCount);
	sensor_clock_host #(.HALF_PERIOD(HALF)) sensor_clock_host_inst (.clk, .rst, .link, .syncRun, .clockStop,
		.writeReq, .writeDivSel, .fastClock, .writeBusy, .writeDone);
	sensor_clock_divider_sync_sva sensor_clock_divider_sync_sva_inst (.clk, .rst, .pixelEnable, .timingReset,
		.frameStart, .activeDivSel, .exposurePendingFlags, .oscillatorInputEn(link.oscillatorInputEn),
		.frameSyncInput(link.frameSyncInput), .systemResetN(link.systemResetN), .writeStrobe(link.writeStrobe),
		.writePreset(link.writePreset), .writePresetValue(link.writePresetValue), .busActive(link.busActive));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			report_and_stop();
		end
	end
	// ****
	// Helpers
	// ****
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Host never lets code 00 through on a fast clock
	function automatic logic [1:0] expect_sel(input logic [1:0] s, input logic fast);
		return (fast && s == 2'h0) ? 2'h1 : s;
	endfunction
	task automatic check(input string what, input logic [15:0] expected, input logic [15:0] seen);
		n_compared++;
		if (seen !== expected) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, expected, seen);
		end
	endtask
	task automatic wait_hi(ref logic sig);
		for (int i = 0; i < 600 && sig !== 1'b1; i++) begin
			@(negedge clk);
		end
	endtask
	task automatic count_to(ref logic sig, input logic [15:0] start);
		gap = start;
		do begin
			@(negedge clk);
			gap++;
		end while (sig !== 1'b1 && gap < 16'h00C8);
	endtask
	task automatic run_write(input logic [1:0] s, input logic fast);
		writeDivSel = s;
		fastClock = fast;
		writeReq = 1'b1;
		@(negedge clk);
		writeReq = 1'b0;
		wait_hi(strobe);
		check("busy", 16'h0001, 16'(writeBusy));
		@(negedge clk);
		check("pending", 16'h0001, 16'(exposurePendingFlags));
		wait_hi(writeDone);
		check("busy end", 16'h0000, 16'(writeBusy));
		clockStop = 1'b0;
		wait_hi(frameStart);
		repeat (2) @(negedge clk);
		check("divsel", 16'(expect_sel(s, fast)), 16'(activeDivSel));
		check("pending clear", 16'h0000, 16'(exposurePendingFlags));
		wait_hi(pixelEnable);
		count_to(pixelEnable, 16'h0000);
		check("pixel period", 16'h0002 << activeDivSel, gap);
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check("reset divsel", 16'h0000, 16'(activeDivSel));
		check("preset", 16'h001E, 16'(pixelCounterPreset));
		for (int k = 3; k >= 0; k--) begin
			run_write(2'(k), 1'b0);
			$display("test divide code %0d done", k);
		end
		run_write(2'h0, 1'b1);
		clockStop = 1'b1;
		repeat (20) @(negedge clk);
		check("clock idle", 16'h0000, 16'(link.oscillatorInputEn));
		check("stopped pixel", 16'h0000, 16'(pixelEnable));
		run_write(2'h2, 1'b0);
		repeat (4) begin
			seed = next_rand(seed);
			run_write(seed[1:0], seed[2]);
		end
		$display("test fast, stopped and random writes done");
		syncRun = 1'b1;
		wait_hi(timingReset);
		@(negedge clk);
		check("sync load", 16'(FRAME - sensor_clock_pkg::SYNC_LEAD_PIXELS), pixelCount);
		count_to(timingReset, 16'h0001);
		check("sync period", 16'(2 * HALF), gap);
		$display("test frame sync done");
		report_and_stop();
	end
endmodule
